/* File: cdc_cfg_chk.sv */
/* concurrent checks on the ports of the excitation/mode block.
   assumes one sys_clk domain with synchronous active-low rstn. */
`timescale 1ns/10ps
`default_nettype none
module cdc_cfg_chk (
	input wire logic                      sys_clk,
	input wire logic                      rstn,
	input wire logic                      scl_in,
	input wire logic                      sda_oe_n,
	input wire logic                      cap_channel_enable,
	input wire logic                      aux_channel_enable,
	input wire logic [15:0]               zero_scale_result,
	input wire cdc_cfg_pkg::exc_drive_t   exc_drive,
	input wire cdc_cfg_pkg::conv_status_t conv_status,
	input wire logic [15:0]               offset_coeff
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_reset_exc: assert property (disable iff (1'b0) !rstn |=> exc_drive == 12'h308)
		else $error("excitation drive not at reset value");
	a_reset_coeff: assert property (disable iff (1'b0) !rstn |=> offset_coeff == 16'h8000)
		else $error("offset coefficient not at reset value");
	a_reset_stat: assert property (disable iff (1'b0) !rstn |=> conv_status == 5'h00)
		else $error("status not clear in reset");
	a_level_low: assert property (exc_drive.low_eighths == 4'h3 - {2'h0, exc_drive.drive_level})
		else $error("low level does not match level code");
	a_level_high: assert property (exc_drive.high_eighths == 4'h5 + {2'h0, exc_drive.drive_level})
		else $error("high level does not match level code");
	a_coeff_load: assert property ($changed(offset_coeff) && $past(rstn) |->
		offset_coeff == $past(zero_scale_result)) else $error("coefficient not from result");
	a_cap_enable: assert property ($rose(conv_status.cap_active) |-> $past(cap_channel_enable))
		else $error("cap conversion without enable");
	a_aux_enable: assert property ($rose(conv_status.aux_active) |-> $past(aux_channel_enable))
		else $error("aux conversion without enable");
	a_pd_quiet: assert property (conv_status.powered_down |->
		!conv_status.cap_active && !conv_status.aux_active) else $error("active in power-down");
	a_sda_phase: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data line changed while clock high");
endmodule
`default_nettype wire

/* File: cdc_cfg_pkg.sv */
/*
 * constants, types and tables shared by the excitation/mode block and its timer.
 * assumes a 10 MHz system clock; conversion times are kept in 0.1 ms ticks.
 */
package cdc_cfg_pkg;

	// register pointers on the two-wire interface
	localparam logic [7:0]  PTR_EXC    = 8'h09;
	localparam logic [7:0]  PTR_CFG    = 8'h0A;
	localparam logic [7:0]  PTR_OFS_HI = 8'h0D;
	localparam logic [7:0]  PTR_OFS_LO = 8'h0E;

	// reset values
	localparam logic [7:0]  EXC_RESET  = 8'h03;
	localparam logic [7:0]  CFG_RESET  = 8'hA0;
	localparam logic [15:0] OFS_RESET  = 16'h8000;

	// field positions
	localparam int EXC_DAC_BIT = 3;
	localparam int EXC_EN_BIT  = 2;
	localparam int LVL_LSB     = 0;
	localparam int AUX_FS_LSB  = 6;
	localparam int CAP_FS_LSB  = 3;
	localparam int MODE_LSB    = 0;

	// device address on the serial bus, value is arbitrary
	localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h2A;

	// timing: clock rate and tick length
	localparam int CLK_HZ        = 10000000;
	localparam int TICK_US       = 100;
	localparam int CYCLES_PER_TICK = (CLK_HZ / 1000000) * TICK_US;

	// conversion times in 0.1 ms ticks
	localparam logic [11:0] CAP_CONV_TICKS [8] = '{12'h0DC, 12'h0EF, 12'h190, 12'h2F8,
	                                              12'h4D8, 12'h604, 12'h730, 12'h891};
	localparam logic [11:0] AUX_CONV_TICKS [4] = '{12'h0C9, 12'h141, 12'h26D, 12'h4C5};

	// excitation low and high levels in eighths of supply per level code
	localparam logic [3:0]  EXC_LOW_EIGHTHS  [4] = '{4'h3, 4'h2, 4'h1, 4'h0};
	localparam logic [3:0]  EXC_HIGH_EIGHTHS [4] = '{4'h5, 4'h6, 4'h7, 4'h8};

	typedef enum logic [2:0] {
		MODE_IDLE       = 3'h0,
		MODE_CONT       = 3'h1,
		MODE_SINGLE     = 3'h2,
		MODE_POWER_DOWN = 3'h3,
		MODE_OFFSET_CAL = 3'h5,
		MODE_GAIN_CAL   = 3'h6
	} op_mode_t;

	typedef enum logic [3:0] {
		S_IDLE      = 4'h0,
		S_ADDR      = 4'h1,
		S_ADDR_ACK  = 4'h3,
		S_PTR       = 4'h2,
		S_PTR_ACK   = 4'h6,
		S_WDATA     = 4'h7,
		S_WDATA_ACK = 4'h5,
		S_RDATA     = 4'h4,
		S_RDATA_ACK = 4'hC
	} ser_state_t;

	typedef struct packed {
		logic       offset_dac_drive_enable;
		logic       input_shield_drive_enable;
		logic [1:0] drive_level;
		logic [3:0] low_eighths;
		logic [3:0] high_eighths;
	} exc_drive_t;

	typedef struct packed {
		logic cap_active;
		logic aux_active;
		logic cap_conv_done;
		logic aux_conv_done;
		logic powered_down;
	} conv_status_t;

endpackage

/* File: cdc_excitation_and_mode_config.sv */
/*
 * excitation setup and rate/mode configuration registers behind a two-wire
 * serial slave with an address pointer, plus the conversion mode sequencer.
 * assumes scl/sda inputs already synchronous to sys_clk; sda is open drain.
 */
// What this block does
// - the two-bit level code picks a swing of 1/8, 1/4, 3/8 or 1/2 supply about mid-supply.
// - the excitation register resets to 0x03.
// - the rate and mode register resets to 0xA0.
// - the capacitive filter code sets the cap conversion time from 22.0 to 219.3 ms.
// - the three-bit mode field selects idle, continuous, single, power-down or a calibration.
// - a mode acts on the capacitive channel only while its channel enable is set.
// - a finished offset calibration overwrites the offset coefficient, reset 0x8000.
`timescale 1ns/10ps
`default_nettype none
module cdc_excitation_and_mode_config #(
	parameter logic [6:0]  DEV_ADDR        = cdc_cfg_pkg::DEV_ADDR_DEFAULT,
	parameter int unsigned CYCLES_PER_TICK = cdc_cfg_pkg::CYCLES_PER_TICK
) (
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	input  wire logic                      scl_in,
	input  wire logic                      sda_in,
	output logic                           sda_out,
	output logic                           sda_oe_n,
	input  wire logic                      cap_channel_enable,
	input  wire logic                      aux_channel_enable,
	input  wire logic [15:0]               zero_scale_result,
	output cdc_cfg_pkg::exc_drive_t        exc_drive,
	output cdc_cfg_pkg::conv_status_t      conv_status,
	output logic [15:0]                    offset_coeff
);
	// serial slave state
	cdc_cfg_pkg::ser_state_t st_reg, st_next;
	logic [3:0]  cnt_reg,  cnt_next;
	logic [7:0]  sh_reg,   sh_next;
	logic [7:0]  ptr_reg,  ptr_next;
	logic        rw_reg,   rw_next;
	logic        mack_reg, mack_next;
	logic        oe_n_reg, oe_n_next;
	logic        scl_prev, sda_prev;
	logic        scl_rise, scl_fall, start_seen, stop_seen;
	logic        wr_en;
	logic [7:0]  wr_ptr, wr_data, rd_val;

	// register and sequencer state
	logic [7:0]  exc_reg,  exc_next;
	logic [7:0]  cfg_reg,  cfg_next;
	logic [15:0] ofs_reg,  ofs_next;
	logic        run_reg,  run_next;
	logic        ch_reg,   ch_next;
	logic        pref_reg, pref_next;
	cdc_cfg_pkg::exc_drive_t   drv_reg, drv_next;
	cdc_cfg_pkg::conv_status_t sts_reg, sts_next;
	cdc_cfg_pkg::op_mode_t     mode;
	logic        t_start, t_abort, t_done, start_ch, start_ok;
	logic [11:0] t_len;
	logic [1:0]  lvl;

	assign scl_rise   = scl_in & ~scl_prev;
	assign scl_fall   = ~scl_in & scl_prev;
	assign start_seen = scl_in & scl_prev & sda_prev & ~sda_in;
	assign stop_seen  = scl_in & scl_prev & ~sda_prev & sda_in;

	// register read mux
	always_comb begin
		if (ptr_reg == cdc_cfg_pkg::PTR_EXC) begin
			rd_val = exc_reg;
		end else if (ptr_reg == cdc_cfg_pkg::PTR_CFG) begin
			rd_val = cfg_reg;
		end else if (ptr_reg == cdc_cfg_pkg::PTR_OFS_HI) begin
			rd_val = ofs_reg[15:8];
		end else if (ptr_reg == cdc_cfg_pkg::PTR_OFS_LO) begin
			rd_val = ofs_reg[7:0];
		end else begin
			rd_val = 8'h00;
		end
	end

	// two-wire slave: address, pointer, write bytes, read bytes with auto-increment
	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		sh_next   = sh_reg;
		ptr_next  = ptr_reg;
		rw_next   = rw_reg;
		mack_next = mack_reg;
		oe_n_next = oe_n_reg;
		wr_en     = 1'b0;
		wr_ptr    = ptr_reg;
		wr_data   = sh_reg;
		if (start_seen) begin
			st_next   = cdc_cfg_pkg::S_ADDR;
			cnt_next  = 4'h0;
			oe_n_next = 1'b1;
		end else if (stop_seen) begin
			st_next   = cdc_cfg_pkg::S_IDLE;
			oe_n_next = 1'b1;
		end else if (scl_rise) begin
			case (st_reg)
				cdc_cfg_pkg::S_ADDR, cdc_cfg_pkg::S_PTR, cdc_cfg_pkg::S_WDATA: begin
					sh_next  = {sh_reg[6:0], sda_in};
					cnt_next = cnt_reg + 4'h1;
				end
				cdc_cfg_pkg::S_RDATA: begin
					cnt_next = cnt_reg + 4'h1;
				end
				cdc_cfg_pkg::S_RDATA_ACK: begin
					mack_next = ~sda_in;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (st_reg)
				cdc_cfg_pkg::S_ADDR: begin
					if (cnt_reg == 4'h8) begin
						cnt_next = 4'h0;
						if (sh_reg[7:1] == DEV_ADDR) begin
							rw_next   = sh_reg[0];
							st_next   = cdc_cfg_pkg::S_ADDR_ACK;
							oe_n_next = 1'b0;
						end else begin
							st_next = cdc_cfg_pkg::S_IDLE;
						end
					end
				end
				cdc_cfg_pkg::S_PTR: begin
					if (cnt_reg == 4'h8) begin
						ptr_next  = sh_reg;
						cnt_next  = 4'h0;
						st_next   = cdc_cfg_pkg::S_PTR_ACK;
						oe_n_next = 1'b0;
					end
				end
				cdc_cfg_pkg::S_WDATA: begin
					if (cnt_reg == 4'h8) begin
						wr_en     = 1'b1;
						ptr_next  = ptr_reg + 8'h01;
						cnt_next  = 4'h0;
						st_next   = cdc_cfg_pkg::S_WDATA_ACK;
						oe_n_next = 1'b0;
					end
				end
				cdc_cfg_pkg::S_ADDR_ACK, cdc_cfg_pkg::S_RDATA_ACK: begin
					if ((st_reg == cdc_cfg_pkg::S_ADDR_ACK) ? rw_reg : mack_reg) begin
						sh_next   = rd_val;
						ptr_next  = ptr_reg + 8'h01;
						cnt_next  = 4'h0;
						oe_n_next = rd_val[7];
						st_next   = cdc_cfg_pkg::S_RDATA;
					end else begin
						oe_n_next = 1'b1;
						st_next   = (st_reg == cdc_cfg_pkg::S_ADDR_ACK) ?
						            cdc_cfg_pkg::S_PTR : cdc_cfg_pkg::S_IDLE;
					end
				end
				cdc_cfg_pkg::S_PTR_ACK, cdc_cfg_pkg::S_WDATA_ACK: begin
					oe_n_next = 1'b1;
					st_next   = cdc_cfg_pkg::S_WDATA;
				end
				cdc_cfg_pkg::S_RDATA: begin
					if (cnt_reg == 4'h8) begin
						cnt_next  = 4'h0;
						oe_n_next = 1'b1;
						st_next   = cdc_cfg_pkg::S_RDATA_ACK;
					end else begin
						sh_next   = {sh_reg[6:0], 1'b0};
						oe_n_next = sh_reg[6];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_reg   <= cdc_cfg_pkg::S_IDLE;
			cnt_reg  <= 4'h0;
			sh_reg   <= 8'h00;
			ptr_reg  <= 8'h00;
			rw_reg   <= 1'b0;
			mack_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			sh_reg   <= sh_next;
			ptr_reg  <= ptr_next;
			rw_reg   <= rw_next;
			mack_reg <= mack_next;
			oe_n_reg <= oe_n_next;
			scl_prev <= scl_in;
			sda_prev <= sda_in;
		end
	end

	// registers and conversion sequencer
	always_comb begin
		exc_next  = exc_reg;
		cfg_next  = cfg_reg;
		ofs_next  = ofs_reg;
		run_next  = run_reg;
		ch_next   = ch_reg;
		pref_next = pref_reg;
		t_start   = 1'b0;
		t_abort   = 1'b0;
		mode      = cdc_cfg_pkg::op_mode_t'(cfg_reg[cdc_cfg_pkg::MODE_LSB +: 3]);
		sts_next  = '0;
		start_ch  = 1'b0;
		start_ok  = 1'b0;
		if (pref_reg && aux_channel_enable) begin
			start_ch = 1'b1;
			start_ok = 1'b1;
		end else if (cap_channel_enable) begin
			start_ok = 1'b1;
		end else if (aux_channel_enable && mode != cdc_cfg_pkg::MODE_OFFSET_CAL) begin
			start_ch = 1'b1;
			start_ok = 1'b1;
		end
		t_len = start_ch ? cdc_cfg_pkg::AUX_CONV_TICKS[cfg_reg[cdc_cfg_pkg::AUX_FS_LSB +: 2]]
		                 : cdc_cfg_pkg::CAP_CONV_TICKS[cfg_reg[cdc_cfg_pkg::CAP_FS_LSB +: 3]];
		if (wr_en && wr_ptr == cdc_cfg_pkg::PTR_EXC) begin
			exc_next = wr_data;
		end
		if (wr_en && wr_ptr == cdc_cfg_pkg::PTR_CFG) begin
			cfg_next  = wr_data;
			t_abort   = 1'b1;
			run_next  = 1'b0;
			pref_next = 1'b0;
		end else if (run_reg) begin
			if (t_done) begin
				run_next               = 1'b0;
				sts_next.cap_conv_done = ~ch_reg;
				sts_next.aux_conv_done = ch_reg;
				if (mode == cdc_cfg_pkg::MODE_OFFSET_CAL && !ch_reg) begin
					ofs_next = zero_scale_result;
				end
				if (mode == cdc_cfg_pkg::MODE_CONT) begin
					pref_next = ~ch_reg;
				end else if (mode == cdc_cfg_pkg::MODE_SINGLE && !ch_reg && aux_channel_enable) begin
					pref_next = 1'b1;
				end else begin
					cfg_next[cdc_cfg_pkg::MODE_LSB +: 3] = cdc_cfg_pkg::MODE_IDLE;
					pref_next = 1'b0;
				end
			end
		end else begin
			case (mode)
				cdc_cfg_pkg::MODE_CONT, cdc_cfg_pkg::MODE_SINGLE,
				cdc_cfg_pkg::MODE_OFFSET_CAL, cdc_cfg_pkg::MODE_GAIN_CAL: begin
					if (start_ok) begin
						t_start  = 1'b1;
						run_next = 1'b1;
						ch_next  = start_ch;
					end else if (mode != cdc_cfg_pkg::MODE_CONT) begin
						cfg_next[cdc_cfg_pkg::MODE_LSB +: 3] = cdc_cfg_pkg::MODE_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
		sts_next.cap_active   = run_next & ~ch_next;
		sts_next.aux_active   = run_next & ch_next;
		sts_next.powered_down = (cfg_next[cdc_cfg_pkg::MODE_LSB +: 3] ==
		                         cdc_cfg_pkg::MODE_POWER_DOWN);
		lvl = exc_next[cdc_cfg_pkg::LVL_LSB +: 2];
		drv_next.offset_dac_drive_enable   = exc_next[cdc_cfg_pkg::EXC_DAC_BIT];
		drv_next.input_shield_drive_enable = exc_next[cdc_cfg_pkg::EXC_EN_BIT];
		drv_next.drive_level               = lvl;
		drv_next.low_eighths               = cdc_cfg_pkg::EXC_LOW_EIGHTHS[lvl];
		drv_next.high_eighths              = cdc_cfg_pkg::EXC_HIGH_EIGHTHS[lvl];
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			exc_reg  <= cdc_cfg_pkg::EXC_RESET;
			cfg_reg  <= cdc_cfg_pkg::CFG_RESET;
			ofs_reg  <= cdc_cfg_pkg::OFS_RESET;
			run_reg  <= 1'b0;
			ch_reg   <= 1'b0;
			pref_reg <= 1'b0;
			drv_reg  <= '{1'b0, 1'b0, 2'h3, 4'h0, 4'h8};
			sts_reg  <= '0;
		end else begin
			exc_reg  <= exc_next;
			cfg_reg  <= cfg_next;
			ofs_reg  <= ofs_next;
			run_reg  <= run_next;
			ch_reg   <= ch_next;
			pref_reg <= pref_next;
			drv_reg  <= drv_next;
			sts_reg  <= sts_next;
		end
	end

	conv_timer #(
		.CYCLES_PER_TICK (CYCLES_PER_TICK)
	) i_conv_timer (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.start     (t_start),
		.abort     (t_abort),
		.len_ticks (t_len),
		.busy      (),
		.done      (t_done)
	);

	assign sda_out      = 1'b0;
	assign sda_oe_n     = oe_n_reg;
	assign exc_drive    = drv_reg;
	assign conv_status  = sts_reg;
	assign offset_coeff = ofs_reg;
endmodule
`default_nettype wire

/* File: cdc_excitation_and_mode_config_bench.sv */
/* self-checking bench for the excitation/mode block driven by a two-wire host model.
   assumes the package, timer, block and host model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module cdc_excitation_and_mode_config_bench;
	localparam logic [6:0] DEV = 7'h35;
	localparam int CPT = 2;
	localparam int CAP_T [8] = '{220, 239, 400, 760, 1240, 1540, 1840, 2193};
	localparam int AUX_T [4] = '{201, 321, 621, 1221};
	logic                      sys_clk = 1'b0;
	logic                      rstn = 1'b0;
	logic                      scl;
	logic                      host_sda;
	logic                      sda_out;
	logic                      sda_oe_n;
	logic                      sda_wire;
	logic                      cap_en = 1'b0;
	logic                      aux_en = 1'b0;
	logic [15:0]               zsr = 16'h0000;
	cdc_cfg_pkg::exc_drive_t   exc_drive;
	cdc_cfg_pkg::conv_status_t conv_status;
	logic [15:0]               offset_coeff;
	int                        bad_count = 0;
	int                        num_checks = 0;
	int                        cap_len = 0;
	int                        aux_len = 0;
	assign sda_wire = host_sda & (sda_oe_n | sda_out);
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cap_len <= conv_status.cap_active ? cap_len + 1 : 0;
		aux_len <= conv_status.aux_active ? aux_len + 1 : 0;
	end
	cdc_excitation_and_mode_config #(.DEV_ADDR(DEV), .CYCLES_PER_TICK(CPT)) i_cdc_excitation_and_mode_config (
		.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .cap_channel_enable(cap_en), .aux_channel_enable(aux_en),
		.zero_scale_result(zsr), .exc_drive(exc_drive), .conv_status(conv_status),
		.offset_coeff(offset_coeff));
	twi_host_model i_twi_host_model (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl),
		.sda(host_sda));
	function automatic logic in_win(int n, int t);
		return n >= t * CPT - 2 && n <= t * CPT + 4;
	endfunction
	task automatic bus_wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		logic       k;
		i_twi_host_model.start();
		i_twi_host_model.byte_io({DEV, 1'b0}, 1'b1, q, k);
		`CHK(k, 1'b0)
		i_twi_host_model.byte_io(p, 1'b1, q, k);
		i_twi_host_model.byte_io(d, 1'b1, q, k);
		i_twi_host_model.stop();
	endtask
	task automatic bus_rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] q;
		logic       k;
		i_twi_host_model.start();
		i_twi_host_model.byte_io({DEV, 1'b0}, 1'b1, q, k);
		`CHK(k, 1'b0)
		i_twi_host_model.byte_io(p, 1'b1, q, k);
		i_twi_host_model.start();
		i_twi_host_model.byte_io({DEV, 1'b1}, 1'b1, q, k);
		i_twi_host_model.byte_io(8'hFF, 1'b1, d, k);
		i_twi_host_model.stop();
	endtask
	task automatic wait_done(input logic cap, output int n);
		int c;
		for (c = 0; c < 6000; c++) begin
			@(negedge sys_clk);
			if ((cap ? conv_status.cap_conv_done : conv_status.aux_conv_done) === 1'b1) break;
		end
		n = cap ? cap_len : aux_len;
		`CHK(c < 6000, 1'b1)
		@(posedge sys_clk);
	endtask
	task automatic t_reset_vals;
		logic [7:0] d;
		logic [7:0] q;
		logic       k;
		`CHK(exc_drive, 12'h308)
		i_twi_host_model.start();
		i_twi_host_model.byte_io({DEV ^ 7'h01, 1'b0}, 1'b1, q, k);
		`CHK(k, 1'b1)
		i_twi_host_model.stop();
		bus_rd(8'h09, d);
		`CHK(d, 8'h03)
		bus_rd(8'h0A, d);
		`CHK(d, 8'hA0)
		bus_wr(8'h0D, 8'h12);
		bus_rd(8'h0D, d);
		`CHK(d, 8'h80)
		bus_rd(8'h0B, d);
		`CHK(d, 8'h00)
	endtask
	task automatic t_levels;
		logic [7:0]  d;
		logic [11:0] e;
		for (int l = 0; l < 4; l++) begin
			bus_wr(8'h09, {4'h0, 2'b11, l[1:0]});
			e = {2'b11, l[1:0], 4'(3 - l), 4'(5 + l)};
			`CHK(exc_drive, e)
		end
		bus_wr(8'h09, 8'h0E);
		bus_rd(8'h09, d);
		`CHK(d, 8'h0E)
	endtask
	task automatic t_cap_times;
		int         n;
		logic [7:0] d;
		cap_en <= 1'b1;
		for (int f = 0; f < 8; f++) begin
			bus_wr(8'h0A, {2'b00, f[2:0], 3'b010});
			wait_done(1'b1, n);
			`CHK(in_win(n, CAP_T[f]), 1'b1)
			bus_rd(8'h0A, d);
			`CHK(d[2:0], 3'b000)
		end
	endtask
	task automatic t_aux_times;
		int n;
		cap_en <= 1'b0;
		aux_en <= 1'b1;
		for (int v = 0; v < 4; v++) begin
			bus_wr(8'h0A, {v[1:0], 6'b000010});
			wait_done(1'b0, n);
			`CHK(in_win(n, AUX_T[v]), 1'b1)
			`CHK(conv_status.cap_active, 1'b0)
		end
	endtask
	task automatic t_calib;
		int         n;
		logic [7:0] d;
		cap_en <= 1'b1;
		aux_en <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			zsr <= i ? 16'h5678 : 16'h1234;
			bus_wr(8'h0A, i ? 8'h06 : 8'h05);
			wait_done(1'b1, n);
			bus_rd(8'h0A, d);
			`CHK(d[2:0], 3'b000)
			`CHK(offset_coeff, 16'h1234)
		end
		bus_rd(8'h0E, d);
		`CHK(d, 8'h34)
	endtask
	task automatic t_modes;
		int         n;
		logic [7:0] d;
		aux_en <= 1'b1;
		bus_wr(8'h0A, 8'h01);
		wait_done(1'b1, n);
		wait_done(1'b0, n);
		`CHK(in_win(n, AUX_T[0]), 1'b1)
		bus_wr(8'h0A, 8'h03);
		`CHK(conv_status.powered_down, 1'b1)
		cap_en <= 1'b0;
		aux_en <= 1'b0;
		bus_wr(8'h0A, 8'h02);
		i_twi_host_model.tick(10);
		`CHK(conv_status.cap_active, 1'b0)
		bus_rd(8'h0A, d);
		`CHK(d[2:0], 3'b000)
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		t_reset_vals();
		t_levels();
		t_cap_times();
		t_aux_times();
		t_calib();
		t_modes();
		wrap_up();
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		bad_count++;
		wrap_up();
	end
endmodule
bind cdc_excitation_and_mode_config cdc_cfg_chk i_cdc_cfg_chk (.sys_clk(sys_clk), .rstn(rstn),
	.scl_in(scl_in), .sda_oe_n(sda_oe_n), .cap_channel_enable(cap_channel_enable),
	.aux_channel_enable(aux_channel_enable), .zero_scale_result(zero_scale_result),
	.exc_drive(exc_drive), .conv_status(conv_status), .offset_coeff(offset_coeff));
`default_nettype wire

/* File: conv_timer.sv */
/*
 * conversion timer: a tick divider and a down counter of ticks.
 * assumes start and abort are one-cycle pulses from the mode sequencer.
 */
`timescale 1ns/10ps
`default_nettype none
module conv_timer #(
	parameter int unsigned CYCLES_PER_TICK = cdc_cfg_pkg::CYCLES_PER_TICK
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        start,
	input  wire logic        abort,
	input  wire logic [11:0] len_ticks,
	output logic             busy,
	output logic             done
);
	localparam int PRE_W = $clog2(CYCLES_PER_TICK + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_TICK - 1);

	logic [PRE_W-1:0] pre_reg,  pre_next;
	logic [11:0]      tick_reg, tick_next;
	logic             busy_reg, busy_next;
	logic             done_reg, done_next;

	always_comb begin
		pre_next  = pre_reg;
		tick_next = tick_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (abort) begin
			busy_next = 1'b0;
		end else if (start) begin
			busy_next = 1'b1;
			pre_next  = '0;
			tick_next = (len_ticks == 12'h000) ? 12'h001 : len_ticks;
		end else if (busy_reg) begin
			if (pre_reg == PRE_LAST) begin
				pre_next = '0;
				if (tick_reg == 12'h001) begin
					busy_next = 1'b0;
					done_next = 1'b1;
				end else begin
					tick_next = tick_reg - 12'h001;
				end
			end else begin
				pre_next = pre_reg + PRE_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pre_reg  <= '0;
			tick_reg <= 12'h000;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			pre_reg  <= pre_next;
			tick_reg <= tick_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
endmodule
`default_nettype wire

/* File: twi_host_model.sv */
/* two-wire host model: start, stop and byte transfers on an open-drain line.
   assumes sda_wire is the resolved line level with a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module twi_host_model (
	input  wire logic sys_clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// data changes only while scl is low
	task automatic bit_io(input logic b, output logic r);
		sda <= b;
		tick(3);
		scl <= 1'b1;
		tick(4);
		r = sda_wire;
		scl <= 1'b0;
		tick(1);
	endtask
	task automatic start();
		tick(1);
		sda <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(3);
		sda <= 1'b0;
		tick(3);
		scl <= 1'b0;
		tick(1);
	endtask
	task automatic stop();
		sda <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(3);
		sda <= 1'b1;
		tick(3);
	endtask
	// msb first, then the ninth bit
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, k);
	endtask
endmodule
`default_nettype wire
